//--- design/pfd_master.sv
// Non-burst PCI master sequencer for FIFO data and descriptor write-back
module pfd_master
	import pfd_pkg::*;
(
	input  wire logic         clock,
	input  wire logic         sys_rst,
	input  wire logic         fifo_xfer_request,
	input  wire logic         fifo_xfer_read,
	input  wire logic [31:0]  fifo_xfer_addr,
	input  wire logic         tx_fifo_at_high,
	input  wire logic         burst_read_enable,
	input  wire logic         burst_write_enable,
	input  wire logic         desc_request,
	input  wire logic [31:0]  desc_base,
	input  wire logic [7:0]   software_style_select,
	input  wire logic [31:0]  descriptor_word_one,
	input  wire logic [31:0]  descriptor_word_two,
	input  wire logic [pfd_pkg::DATA_W-1:0] rx_in_data,
	input  wire logic         rx_in_valid,
	output logic              rx_in_ready,
	output logic [31:0]       tx_out_data,
	output logic              tx_out_valid,
	output logic              xfer_done,
	output logic              desc_done,
	output logic              burst_path_select,
	output logic              master_busy,
	output logic              req_n,
	input  wire logic         gnt_n,
	output logic              frame_n,
	output logic              frame_oe_n,
	output logic              irdy_n,
	output logic              irdy_oe_n,
	output logic [31:0]       ad_out,
	input  wire logic [31:0]  ad_in,
	output logic              ad_oe_n,
	output logic [3:0]        cbe_n,
	output logic              cbe_oe_n,
	input  wire logic         trdy_n,
	input  wire logic         stop_n
);
	import pfd_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	pfd_state_t  st_reg;
	pfd_state_t  st_next;
	logic        job_desc_reg;
	logic        job_read_reg;
	logic        step_reg;
	logic [31:0] addr_reg;
	logic [31:0] base_reg;
	logic [7:0]  style_reg;
	logic [31:0] one_reg;
	logic [31:0] two_reg;
	logic [31:0] fifo_data;
	logic        fifo_valid;
	logic        fifo_pop;
	logic        burst_dir;
	logic        start_desc;
	logic        start_fifo;
	logic        two_step;
	logic        phase_ok;
	logic        phase_retry;
	logic        more;
	logic        resume_reg;
	logic [31:0] desc_addr;
	logic [31:0] desc_data;
	logic [3:0]  desc_be_n;
	logic [31:0] phase_addr;
	logic [31:0] phase_data;
	logic [3:0]  phase_be_n;

	// ----------------------------------------
	// Receive data buffer
	// ----------------------------------------
	pfd_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
		.clock     (clock),
		.sys_rst   (sys_rst),
		.in_data   (rx_in_data),
		.in_valid  (rx_in_valid),
		.in_ready  (rx_in_ready),
		.out_data  (fifo_data),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop)
	);

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	assign burst_dir   = fifo_xfer_read ? burst_read_enable : burst_write_enable;
	// Quiet cycle after a done pulse, so a request still standing is not retaken
	assign start_desc  = desc_request & ~desc_done & ~xfer_done;
	assign start_fifo  = fifo_xfer_request & ~burst_dir & (fifo_xfer_read | fifo_valid)
		& ~desc_done & ~xfer_done;
	assign two_step    = (style_reg == STYLE_TWO) | (style_reg == STYLE_THREE);
	assign phase_ok    = (st_reg == ST_DATA) & ~trdy_n;
	assign phase_retry = (st_reg == ST_DATA) & trdy_n & ~stop_n;
	assign fifo_pop    = phase_ok & ~job_desc_reg & ~job_read_reg;
	// Period length set by FIFO levels, descriptor style and grant, never by a latency count
	assign more = job_desc_reg ? (two_step & step_reg) :
		job_read_reg ? ~tx_fifo_at_high : fifo_valid;

	// Descriptor write-back order per style
	assign desc_addr = base_reg + ((two_step & ~step_reg) ? OFS_WORD_TWO : OFS_WORD_ONE);
	assign desc_data = two_step ? (step_reg ? one_reg : two_reg) :
		{two_reg[15:0], one_reg[15:0]};
	assign desc_be_n = (two_step & step_reg) ? BE_UPPER_N : BE_ALL_N;

	assign phase_addr = job_desc_reg ? desc_addr : addr_reg;
	assign phase_data = job_desc_reg ? desc_data : fifo_data;
	assign phase_be_n = job_desc_reg ? desc_be_n : BE_ALL_N;

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;
		case (st_reg)
			ST_IDLE: if (start_desc | start_fifo) st_next = ST_REQ;
			ST_REQ:  if (~gnt_n) st_next = ST_ADDR;
			ST_ADDR: st_next = ST_DATA;
			ST_DATA: begin
				if (phase_ok)
					st_next = ST_TURN;
				else if (phase_retry)
					st_next = ST_REL;
			end
			ST_TURN: st_next = (more & ~gnt_n) ? ST_ADDR : ST_REL;
			ST_REL:  st_next = (job_desc_reg & resume_reg) ? ST_REQ : ST_IDLE;
			default: st_next = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			st_reg       <= ST_IDLE;
			job_desc_reg <= 1'b0;
			job_read_reg <= 1'b0;
			step_reg     <= 1'b0;
			addr_reg     <= '0;
			base_reg     <= '0;
			style_reg    <= '0;
			one_reg      <= '0;
			two_reg      <= '0;
			resume_reg   <= 1'b0;
		end else begin
			st_reg <= st_next;
			if (st_reg == ST_IDLE && start_desc) begin
				job_desc_reg <= 1'b1;
				step_reg     <= 1'b0;
				base_reg     <= desc_base;
				style_reg    <= software_style_select;
				one_reg      <= descriptor_word_one;
				two_reg      <= descriptor_word_two;
			end else if (st_reg == ST_IDLE && start_fifo) begin
				job_desc_reg <= 1'b0;
				job_read_reg <= fifo_xfer_read;
				addr_reg     <= fifo_xfer_addr;
			end
			if (phase_ok && job_desc_reg)
				step_reg <= ~step_reg;
			if (phase_ok && !job_desc_reg)
				addr_reg <= addr_reg + ADDR_STEP;
			// Write-back left unfinished by retry or preemption
			if (st_next == ST_REL && st_reg != ST_REL)
				resume_reg <= phase_retry | more;
		end
	end

	// ----------------------------------------
	// Pin and status registers
	// ----------------------------------------
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			req_n             <= RST_PIN_N;
			frame_n           <= RST_PIN_N;
			frame_oe_n        <= RST_PIN_N;
			irdy_n            <= RST_PIN_N;
			irdy_oe_n         <= RST_PIN_N;
			ad_out            <= '0;
			ad_oe_n           <= RST_PIN_N;
			cbe_n             <= '1;
			cbe_oe_n          <= RST_PIN_N;
			tx_out_data       <= '0;
			tx_out_valid      <= 1'b0;
			xfer_done         <= 1'b0;
			desc_done         <= 1'b0;
			burst_path_select <= 1'b0;
			master_busy       <= 1'b0;
		end else begin
			req_n     <= ~(st_next == ST_REQ || st_next == ST_ADDR || st_next == ST_DATA
				|| st_next == ST_TURN);
			frame_n   <= ~(st_next == ST_ADDR);
			frame_oe_n <= ~(st_next == ST_ADDR || st_next == ST_DATA);
			irdy_n    <= ~(st_next == ST_DATA);
			irdy_oe_n <= ~(st_next == ST_ADDR || st_next == ST_DATA);
			cbe_oe_n  <= ~(st_next == ST_ADDR || st_next == ST_DATA);
			if (st_next == ST_ADDR) begin
				ad_out  <= phase_addr;
				ad_oe_n <= 1'b0;
				cbe_n   <= (job_read_reg & ~job_desc_reg) ? CMD_MEM_READ : CMD_MEM_WRITE;
			end else if (st_reg == ST_ADDR) begin
				ad_out  <= phase_data;
				ad_oe_n <= job_read_reg & ~job_desc_reg;
				cbe_n   <= phase_be_n;
			end else if (st_next != ST_DATA) begin
				ad_oe_n <= 1'b1;
			end
			tx_out_valid      <= phase_ok & job_read_reg & ~job_desc_reg;
			tx_out_data       <= ad_in;
			xfer_done         <= (st_reg == ST_REL) & ~job_desc_reg;
			desc_done         <= (st_reg == ST_REL) & job_desc_reg & (st_next == ST_IDLE);
			burst_path_select <= fifo_xfer_request & burst_dir;
			master_busy       <= st_next != ST_IDLE;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	logic [31:0] last_addr_reg;
	logic        in_period_reg;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			last_addr_reg <= '0;
			in_period_reg <= 1'b0;
		end else begin
			if (!frame_n && !job_desc_reg)
				last_addr_reg <= ad_out;
			in_period_reg <= (st_reg == ST_TURN) | (in_period_reg & st_reg != ST_REL
				& st_reg != ST_IDLE);
		end
	end

	frame_single_a: assert property (!frame_n |=> frame_n)
		else $error("frame held past address phase");
	addr_data_a: assert property (!frame_n |=> !irdy_n ##0 !cbe_oe_n)
		else $error("address phase not followed by data phase");
	hold_trdy_a: assert property (!irdy_n && trdy_n && stop_n |=> !irdy_n && $stable(ad_out))
		else $error("data phase dropped before target ready");
	style_zero_a: assert property (st_reg == ST_ADDR && job_desc_reg && !two_step
		|=> ad_out == {two_reg[15:0], one_reg[15:0]} && cbe_n == BE_ALL_N)
		else $error("style zero data wrong");
	style_two_order_a: assert property (!frame_n && job_desc_reg && two_step
		|-> ad_out == base_reg + (step_reg ? OFS_WORD_ONE : OFS_WORD_TWO))
		else $error("style two address order wrong");
	ascend_addr_a: assert property (!frame_n && !job_desc_reg && in_period_reg
		|-> ad_out == last_addr_reg + ADDR_STEP)
		else $error("addresses not ascending");
	read_high_stop_a: assert property (st_reg == ST_TURN && job_read_reg && !job_desc_reg
		&& tx_fifo_at_high |=> st_reg == ST_REL)
		else $error("read continued past high mark");
	rx_more_go_a: assert property (st_reg == ST_TURN && !job_desc_reg && !job_read_reg
		&& fifo_valid && !gnt_n |=> st_reg == ST_ADDR ##1 !irdy_n)
		else $error("available receive word not moved");
	grant_start_a: assert property (st_reg == ST_REQ && !gnt_n |=> !frame_n)
		else $error("grant not followed by address phase");
	burst_refuse_a: assert property (st_reg == ST_IDLE && !desc_request && fifo_xfer_request
		&& fifo_xfer_read && burst_read_enable |=> st_reg == ST_IDLE)
		else $error("non-burst path took burst-enabled request");

	desc_cov_c: cover property (desc_done && two_step);
	read_cov_c: cover property (tx_out_valid ##[1:20] tx_out_valid);
	write_cov_c: cover property (fifo_pop ##[1:10] fifo_pop);
	retry_cov_c: cover property (phase_retry);

endmodule // pfd_master

//--- design/pfd_pkg.sv
// Package of constants and types for the bus-master FIFO and descriptor sequencer
// Notes on behaviour
// - Style zero write-back starts with one access at offset 04h: word two, word one low halves.
// - Style two writes full word two at 08h first, then word one upper half.
// - Microcode requests FIFO transfers; after grant, consecutive cycles run before release.
// - One mastership period: single direction, contiguous ascending addresses.
// - Without bursting, each transfer is one address phase then one data phase.
// - FRAME is deasserted right after every address phase.
// - Reads run until transmit FIFO high mark, writes until receive FIFO drains.
// - Receive data arriving during the period is still moved in that period.
// - Latency timer plays no part in ending non-burst mastership.
// - Bursting only when the read or write burst enable bit for that direction is set.
package pfd_pkg;

	localparam int        DATA_W         = 32;
	localparam int        FIFO_DEPTH     = 8;
	localparam int        FIFO_AW        = 3;
	localparam logic [3:0] CMD_MEM_READ  = 4'h6;
	localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
	localparam logic [3:0] BE_ALL_N      = 4'h0;
	localparam logic [3:0] BE_UPPER_N    = 4'h3;
	localparam logic [31:0] OFS_WORD_ONE = 32'h0000_0004;
	localparam logic [31:0] OFS_WORD_TWO = 32'h0000_0008;
	localparam logic [31:0] ADDR_STEP    = 32'h0000_0004;
	localparam logic [7:0] STYLE_TWO     = 8'h02;
	localparam logic [7:0] STYLE_THREE   = 8'h03;
	localparam logic      RST_PIN_N      = 1'b1;
	localparam logic [FIFO_AW:0] RST_COUNT = 4'h0;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_REQ  = 3'b001,
		ST_ADDR = 3'b010,
		ST_DATA = 3'b011,
		ST_TURN = 3'b100,
		ST_REL  = 3'b101
	} pfd_state_t;

endpackage

//--- design/pfd_fifo.sv
// Receive data FIFO with registered output stage
module pfd_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8,
	parameter int AW    = 3
) (
	input  wire logic             clock,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	logic [AW:0]      count_next;
	logic             push;
	logic             load;

	assign push       = in_valid & in_ready;
	assign load       = (count_reg != '0) & (~out_valid | out_ready);
	assign count_next = count_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
			in_ready   <= 1'b0;
			out_valid  <= 1'b0;
		end else begin
			wr_ptr_reg <= wr_ptr_reg + AW'(push);
			rd_ptr_reg <= rd_ptr_reg + AW'(load);
			count_reg  <= count_next;
			in_ready   <= count_next != (AW+1)'(DEPTH);
			if (load)
				out_valid <= 1'b1;
			else if (out_ready)
				out_valid <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (push)
			mem[wr_ptr_reg] <= in_data;
		if (load)
			out_data <= mem[rd_ptr_reg];
	end

endmodule // pfd_fifo

//--- sim/pfd_target_model.sv
// PCI arbiter and memory target model facing the sequencer
module pfd_target_model (
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic        req_n,
	output logic             gnt_n,
	input  wire logic        frame_n,
	input  wire logic        frame_oe_n,
	input  wire logic        irdy_n,
	input  wire logic        irdy_oe_n,
	input  wire logic [31:0] ad_out,
	input  wire logic [3:0]  cbe_n,
	output logic [31:0]      ad_in,
	output logic             trdy_n,
	output logic             stop_n,
	input  wire logic [3:0]  wait_states,
	input  wire logic [7:0]  grant_limit,
	input  wire logic        retry_en
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] log_addr [64];
	logic [31:0] log_data [64];
	logic [3:0]  log_be [64];
	logic [3:0]  log_cmd [64];
	int          log_count;
	logic [31:0] addr_reg;
	logic [3:0]  cmd_reg;
	logic [3:0]  wait_reg;
	logic [7:0]  phases;
	logic        retried;
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			gnt_n <= 1'b1;
			trdy_n <= 1'b1;
			stop_n <= 1'b1;
			ad_in <= 32'h0;
			log_count <= 0;
			phases <= 8'h0;
			wait_reg <= 4'h0;
			retried <= 1'b0;
		end else begin
			gnt_n <= req_n | (phases >= grant_limit);
			if (req_n)
				phases <= 8'h0;
			if (!frame_oe_n && !frame_n) begin
				addr_reg <= ad_out;
				cmd_reg <= cbe_n;
				wait_reg <= 4'h0;
			end
			if (!retry_en)
				retried <= 1'b0;
			if (trdy_n && stop_n && !irdy_oe_n && !irdy_n && wait_reg >= wait_states) begin
				if (retry_en && !retried) begin
					stop_n <= 1'b0;
					retried <= 1'b1;
				end else begin
					trdy_n <= 1'b0;
					ad_in <= addr_reg ^ 32'h5a5a_0000;
					log_addr[log_count] <= addr_reg;
					log_data[log_count] <= ad_out;
					log_be[log_count] <= cbe_n;
					log_cmd[log_count] <= cmd_reg;
					log_count <= log_count + 1;
					phases <= phases + 8'h1;
				end
			end else begin
				trdy_n <= 1'b1;
				stop_n <= 1'b1;
				ad_in <= ~ad_in;
				if (!irdy_oe_n && !irdy_n)
					wait_reg <= wait_reg + 4'h1;
			end
		end
	end
endmodule // pfd_target_model

//--- sim/pci_master_fifo_dma_sequencer_test.sv
// Self-checking bench for the non-burst master sequencer
module pci_master_fifo_dma_sequencer_test;
	timeunit 1ns;
	timeprecision 1ps;
	import pfd_pkg::*;
	logic clock, sys_rst, fifo_xfer_request, fifo_xfer_read, tx_fifo_at_high, desc_request;
	logic burst_read_enable, burst_write_enable, rx_in_valid, rx_in_ready, tx_out_valid;
	logic xfer_done, desc_done, burst_path_select, master_busy, req_n, gnt_n, frame_n;
	logic frame_oe_n, irdy_n, irdy_oe_n, ad_oe_n, cbe_oe_n, trdy_n, stop_n, frame_q, retry_en;
	logic [31:0] fifo_xfer_addr, desc_base, descriptor_word_one, descriptor_word_two;
	logic [31:0] rx_in_data, tx_out_data, ad_out, ad_in, rd_base;
	logic [7:0]  software_style_select, grant_limit;
	logic [3:0]  cbe_n, wait_states;
	int          num_errors, checked, cycles, rd_cnt, pushed;
	pfd_master dut (.clock, .sys_rst, .fifo_xfer_request, .fifo_xfer_read, .fifo_xfer_addr,
		.tx_fifo_at_high, .burst_read_enable, .burst_write_enable, .desc_request, .desc_base,
		.software_style_select, .descriptor_word_one, .descriptor_word_two, .rx_in_data,
		.rx_in_valid, .rx_in_ready, .tx_out_data, .tx_out_valid, .xfer_done, .desc_done,
		.burst_path_select, .master_busy, .req_n, .gnt_n, .frame_n, .frame_oe_n, .irdy_n,
		.irdy_oe_n, .ad_out, .ad_in, .ad_oe_n, .cbe_n, .cbe_oe_n, .trdy_n, .stop_n);
	pfd_target_model model (.clock, .sys_rst, .req_n, .gnt_n, .frame_n, .frame_oe_n, .irdy_n,
		.irdy_oe_n, .ad_out, .cbe_n, .ad_in, .trdy_n, .stop_n, .wait_states, .grant_limit,
		.retry_en);
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task report_and_stop;
		if (num_errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			report_and_stop;
		end
		if (frame_oe_n === 1'b0) begin
			check({31'h0, frame_n | frame_q}, 32'h1);
			check({29'h0, cbe_oe_n, irdy_oe_n, ad_oe_n & ~frame_n}, 32'h0);
			check({31'h0, master_busy}, 32'h1);
		end
		frame_q <= frame_n;
		if (tx_out_valid === 1'b1) begin
			check(tx_out_data, (rd_base + 32'(rd_cnt) * 4) ^ 32'h5a5a_0000);
			rd_cnt++;
			if (rd_cnt == 2)
				tx_fifo_at_high <= 1'b1;
		end
	end
	task run_job(input bit desc);
		int n;
		@(posedge clock);
		if (desc) desc_request <= 1'b1;
		else fifo_xfer_request <= 1'b1;
		for (n = 0; n < 600; n++) begin
			@(posedge clock);
			if ((desc ? desc_done : xfer_done) === 1'b1) break;
		end
		check(32'(n < 600), 32'h1);
		desc_request <= 1'b0;
		fifo_xfer_request <= 1'b0;
		repeat (2) @(posedge clock);
	endtask
	task push(input logic [31:0] d, output bit ok);
		ok = 0;
		@(posedge clock);
		rx_in_data <= d;
		rx_in_valid <= 1'b1;
		repeat (4) begin
			@(posedge clock);
			if (rx_in_ready === 1'b1) begin
				ok = 1;
				pushed++;
				break;
			end
		end
		rx_in_valid <= 1'b0;
	endtask
	task test_desc(input logic [7:0] s);
		int b;
		logic [31:0] base;
		b = model.log_count;
		base = 32'h1000 + 32'(s) * 16;
		software_style_select <= s;
		desc_base <= base;
		descriptor_word_one <= 32'h8123_4567;
		descriptor_word_two <= 32'h9abc_def0;
		run_job(1);
		check(32'(model.log_cmd[b]), 32'(CMD_MEM_WRITE));
		check(32'(model.log_be[b]), 32'(BE_ALL_N));
		if (s == 8'h00) begin
			check(32'(model.log_count - b), 32'h1);
			check(model.log_addr[b], base + 32'h4);
			check(model.log_data[b], 32'hdef0_4567);
		end else begin
			check(32'(model.log_count - b), 32'h2);
			check(model.log_addr[b], base + 32'h8);
			check(model.log_data[b], 32'h9abc_def0);
			check(model.log_addr[b + 1], base + 32'h4);
			check({16'h0, model.log_data[b + 1][31:16]}, 32'h8123);
			check(32'(model.log_be[b + 1]), 32'(BE_UPPER_N));
		end
	endtask
	task test_fifo_write;
		bit ok;
		int b;
		b = model.log_count;
		pushed = 0;
		wait_states <= 4'h3;
		fifo_xfer_addr <= 32'h2000;
		push(32'hc0de_0000, ok);
		push(32'hc0de_0001, ok);
		fork
			run_job(0);
			begin
				push(32'hc0de_0002, ok);
				push(32'hc0de_0003, ok);
			end
		join
		check(32'(model.log_count - b), 32'h4);
		for (int i = 0; i < 4; i++) begin
			check(model.log_addr[b + i], 32'h2000 + 32'(i) * 4);
			check(model.log_data[b + i], 32'hc0de_0000 + 32'(i));
			check(32'(model.log_cmd[b + i]), 32'(CMD_MEM_WRITE));
		end
	endtask
	task test_fill_preempt;
		bit ok;
		int b;
		b = model.log_count;
		pushed = 0;
		ok = 1;
		wait_states <= 4'h1;
		fifo_xfer_addr <= 32'h3000;
		for (int n = 0; n < 16 && ok; n++)
			push(32'hbeef_0000 + 32'(n), ok);
		check(32'(pushed >= FIFO_DEPTH), 32'h1);
		grant_limit <= 8'h3;
		run_job(0);
		check(32'(model.log_count - b), 32'h3);
		grant_limit <= 8'hff;
		fifo_xfer_addr <= 32'h300c;
		run_job(0);
		check(32'(model.log_count - b), 32'(pushed));
		for (int i = 0; i < pushed; i++) begin
			check(model.log_addr[b + i], 32'h3000 + 32'(i) * 4);
			check(model.log_data[b + i], 32'hbeef_0000 + 32'(i));
		end
	endtask
	task test_burst(input bit rd);
		bit ok;
		int n;
		n = 0;
		push(32'h0bad_0000, ok);
		fifo_xfer_read <= rd;
		burst_read_enable <= rd;
		burst_write_enable <= !rd;
		fifo_xfer_request <= 1'b1;
		repeat (20) begin
			@(posedge clock);
			if (req_n === 1'b0) n++;
		end
		check(32'(n), 32'h0);
		check({31'h0, burst_path_select}, 32'h1);
		fifo_xfer_request <= 1'b0;
	endtask
	task test_read;
		int b;
		b = model.log_count;
		rd_base = 32'h4000;
		rd_cnt = 0;
		burst_read_enable <= 1'b0;
		burst_write_enable <= 1'b1;
		tx_fifo_at_high <= 1'b0;
		wait_states <= 4'h0;
		fifo_xfer_read <= 1'b1;
		fifo_xfer_addr <= 32'h4000;
		run_job(0);
		check(32'(rd_cnt), 32'(model.log_count - b));
		check(32'(rd_cnt >= 2 && rd_cnt <= 3), 32'h1);
		for (int i = 0; i < rd_cnt; i++)
			check(32'(model.log_cmd[b + i]), 32'(CMD_MEM_READ));
	endtask
	initial begin
		{sys_rst, fifo_xfer_request, fifo_xfer_read, tx_fifo_at_high, desc_request} = 5'h10;
		{burst_read_enable, burst_write_enable, rx_in_valid, retry_en, frame_q} = 5'h01;
		{fifo_xfer_addr, desc_base, descriptor_word_one, descriptor_word_two} = 128'h0;
		{rx_in_data, rd_base, software_style_select, wait_states} = 76'h0;
		grant_limit = 8'hff;
		repeat (4) @(posedge clock);
		sys_rst <= 1'b0;
		test_desc(8'h00);
		test_desc(8'h02);
		test_desc(8'h03);
		retry_en <= 1'b1;
		test_desc(8'h02);
		check({31'h0, model.retried}, 32'h1);
		retry_en <= 1'b0;
		test_fifo_write;
		test_fill_preempt;
		test_burst(0);
		test_burst(1);
		test_read;
		report_and_stop;
	end
endmodule // pci_master_fifo_dma_sequencer_test
